/* File: prc_rom_ctrl.sv */
//----------------------------------------------------------------------
// Purpose: Host controller reading a page-mode ROM in word or byte organisation.
// Assumes: One request at a time; data pins are sampled through two flops.
// Notes:   Reads in the same page and organisation as the last read since power on use the short in-page wait.
//----------------------------------------------------------------------
`timescale 1ns/100ps
module prc_rom_ctrl #(
  parameter int unsigned POWER_ON_CYCLES  = prc_pkg::POWER_ON_CYC,
  parameter int unsigned POWER_OFF_CYCLES = prc_pkg::POWER_OFF_CYC
) (
  input  wire logic                        sys_clk_in,     // System clock, 100 MHz.
  input  wire logic                        rst_b_in,       // Asynchronous reset, active low.
  input  wire logic                        req_valid_in,   // Read request.
  input  wire prc_pkg::prc_req_t           req_in,         // Request address and width.
  output logic                             req_ready_out,  // Ready to take a request.
  output logic                             rd_valid_out,   // Read data pulse.
  output logic [prc_pkg::DATA_W-1:0]       rd_data_out,    // Read data.
  input  wire logic                        pwr_off_in,     // Request to remove device supply.
  output logic                             pwr_en_out,     // Device supply enable.
  output prc_pkg::prc_pins_t               pins_out,       // Address and controls to device.
  input  wire logic [prc_pkg::DATA_W-1:0]  data_pins_in    // Device data pins.
);

  localparam int unsigned TW = 24;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  prc_pkg::prc_state_t                  state_ff;
  prc_pkg::prc_state_t                  nxt_state;
  prc_pkg::prc_pins_t                   pins_ff;
  logic [prc_pkg::DATA_W-1:0]           sync1_ff;
  logic [prc_pkg::DATA_W-1:0]           sync2_ff;
  logic                                 ready_ff;
  logic                                 rd_valid_ff;
  logic [prc_pkg::DATA_W-1:0]           rd_data_ff;
  logic                                 pwr_en_ff;
  logic                                 page_ok_ff;
  logic                                 last_byte_ff;
  logic [prc_pkg::BYTE_ADDR_W-1:0]      last_addr_ff;
  logic                                 tmr_load;
  logic [TW-1:0]                        tmr_count;
  logic                                 tmr_done;
  logic                                 take;
  logic                                 in_page;
  logic                                 boot_ff;

  // Compares page numbers of two addresses for the chosen organisation.
  function automatic logic same_page(input logic [prc_pkg::BYTE_ADDR_W-1:0] a,
                                     input logic [prc_pkg::BYTE_ADDR_W-1:0] b,
                                     input logic                            byte_mode);
    if (byte_mode) begin
      same_page = (a[prc_pkg::BYTE_ADDR_W-1:prc_pkg::BYTE_PAGE_W] ==
                   b[prc_pkg::BYTE_ADDR_W-1:prc_pkg::BYTE_PAGE_W]);
    end else begin
      same_page = (a[prc_pkg::WORD_ADDR_W-1:prc_pkg::WORD_PAGE_W] ==
                   b[prc_pkg::WORD_ADDR_W-1:prc_pkg::WORD_PAGE_W]);
    end
  endfunction : same_page

  assign take    = req_valid_in && ready_ff;
  assign in_page = page_ok_ff && (last_byte_ff == req_in.byte_mode) &&
                   same_page(req_in.addr, last_addr_ff, req_in.byte_mode);

  prc_timer #(
    .W (TW)
  ) u_timer (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .load_in    (tmr_load),
    .count_in   (tmr_count),
    .done_out   (tmr_done)
  );

  // ----------------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    tmr_load  = 1'b0;
    tmr_count = '0;
    unique case (state_ff)
      prc_pkg::PRC_POWER_ON: begin
        if (boot_ff) begin
          tmr_load  = 1'b1;
          tmr_count = TW'(POWER_ON_CYCLES);
        end else if (tmr_done) begin
          nxt_state = prc_pkg::PRC_IDLE;
        end
      end
      prc_pkg::PRC_IDLE: begin
        if (pwr_off_in) begin
          nxt_state = prc_pkg::PRC_POWER_OFF;
          tmr_load  = 1'b1;
          tmr_count = TW'(prc_pkg::OUT_DISABLE_CYC);
        end else if (take && in_page) begin
          nxt_state = prc_pkg::PRC_PAGE;
          tmr_load  = 1'b1;
          tmr_count = TW'(prc_pkg::IN_PAGE_CYC);
        end else if (take) begin
          nxt_state = prc_pkg::PRC_RANDOM;
          tmr_load  = 1'b1;
          tmr_count = TW'(prc_pkg::RANDOM_READ_CYC);
        end
      end
      prc_pkg::PRC_RANDOM, prc_pkg::PRC_PAGE: begin
        if (tmr_done) begin
          nxt_state = prc_pkg::PRC_IDLE;
        end
      end
      prc_pkg::PRC_POWER_OFF: begin
        if (tmr_done) begin
          nxt_state = prc_pkg::PRC_OFF_WAIT;
          tmr_load  = 1'b1;
          tmr_count = TW'(POWER_OFF_CYCLES);
        end
      end
      prc_pkg::PRC_OFF_WAIT: begin
        if (tmr_done && !pwr_off_in) begin
          nxt_state = prc_pkg::PRC_POWER_ON;
          tmr_load  = 1'b1;
          tmr_count = TW'(POWER_ON_CYCLES);
        end
      end
      default: begin
        nxt_state = prc_pkg::PRC_IDLE;
      end
    endcase
  end

  // The timer resets to zero, so the power-on wait is loaded while boot_ff is set.

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      boot_ff <= 1'b1;
    end else begin
      boot_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= prc_pkg::PRC_POWER_ON;
    end else if (boot_ff) begin
      state_ff <= prc_pkg::PRC_POWER_ON;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------------
  // Device pins
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pins_ff            <= '0;
      pins_ff.chip_sel_b <= 1'b1;
      pins_ff.out_gate_b <= 1'b1;
      pins_ff.width_sel_b <= 1'b1;
    end else if (take && state_ff == prc_pkg::PRC_IDLE && !pwr_off_in) begin
      pins_ff.addr            <= req_in.byte_mode ? req_in.addr[prc_pkg::BYTE_ADDR_W-1:1]
                                                   : req_in.addr[prc_pkg::WORD_ADDR_W-1:0];
      pins_ff.width_sel_b     <= !req_in.byte_mode;
      pins_ff.top_data_pin    <= req_in.addr[0];
      pins_ff.top_data_pin_oe <= req_in.byte_mode;
      pins_ff.chip_sel_b      <= 1'b0;
      pins_ff.out_gate_b      <= 1'b0;
    end else if (state_ff == prc_pkg::PRC_POWER_ON || nxt_state == prc_pkg::PRC_POWER_OFF ||
                 state_ff == prc_pkg::PRC_POWER_OFF || state_ff == prc_pkg::PRC_OFF_WAIT) begin
      pins_ff.chip_sel_b      <= 1'b1;
      pins_ff.out_gate_b      <= 1'b1;
      pins_ff.top_data_pin_oe <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwr_en_ff <= 1'b0;
    end else if (state_ff == prc_pkg::PRC_OFF_WAIT || state_ff == prc_pkg::PRC_POWER_OFF) begin
      pwr_en_ff <= 1'b0;
    end else begin
      pwr_en_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Page tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      page_ok_ff   <= 1'b0;
      last_addr_ff <= '0;
      last_byte_ff <= 1'b0;
    end else if (state_ff != prc_pkg::PRC_IDLE && state_ff != prc_pkg::PRC_RANDOM &&
                 state_ff != prc_pkg::PRC_PAGE) begin
      page_ok_ff <= 1'b0;
    end else if (take && !pwr_off_in) begin
      page_ok_ff   <= 1'b1;
      last_addr_ff <= req_in.addr;
      last_byte_ff <= req_in.byte_mode;
    end
  end

  // ----------------------------------------------------------------------
  // Data capture
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= data_pins_in;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= '0;
    end else if ((state_ff == prc_pkg::PRC_RANDOM || state_ff == prc_pkg::PRC_PAGE) && tmr_done) begin
      rd_valid_ff <= 1'b1;
      if (last_byte_ff) begin
        rd_data_ff <= {{(prc_pkg::DATA_W-prc_pkg::BYTE_W){1'b0}}, sync2_ff[prc_pkg::BYTE_W-1:0]};
      end else begin
        rd_data_ff <= sync2_ff;
      end
    end else begin
      rd_valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= (nxt_state == prc_pkg::PRC_IDLE) && !boot_ff && !take;
    end
  end

  assign req_ready_out = ready_ff;
  assign rd_valid_out  = rd_valid_ff;
  assign rd_data_out   = rd_data_ff;
  assign pwr_en_out    = pwr_en_ff;
  assign pins_out      = pins_ff;

endmodule : prc_rom_ctrl

/* File: prc_pkg.sv */
//----------------------------------------------------------------------
// Purpose: Shared constants and types for the page-mode ROM read controller.
// Assumes: 100 MHz system clock, 10 ns period.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
//----------------------------------------------------------------------
package prc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // ----------------------------------------------------------------------
  // Device timing
  // ----------------------------------------------------------------------
  localparam int unsigned RANDOM_READ_DELAY_NS = 105;
  localparam int unsigned IN_PAGE_DELAY_NS     = 25;
  localparam int unsigned OUT_DISABLE_NS       = 20;
  localparam int unsigned POWER_ON_WAIT_US     = 1000;
  localparam int unsigned POWER_OFF_WAIT_US    = 1000;

  // Least times round up to whole cycles; one cycle of margin is added to the two read delays for the sampling flops.
  localparam int unsigned RANDOM_READ_CYC = (RANDOM_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int unsigned IN_PAGE_CYC     = (IN_PAGE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int unsigned OUT_DISABLE_CYC = (OUT_DISABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWER_ON_CYC    = (POWER_ON_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWER_OFF_CYC   = (POWER_OFF_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Organisation
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_ADDR_W  = 25;
  localparam int unsigned BYTE_ADDR_W  = 26;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned WORD_PAGE_W  = 3;
  localparam int unsigned BYTE_PAGE_W  = 4;
  localparam int unsigned BYTE_W       = 8;
  localparam int unsigned TOP_DATA_BIT = 15;

  // Read request from the user side; byte_mode selects 8-bit organisation.
  typedef struct packed {
    logic [BYTE_ADDR_W-1:0] addr;
    logic                   byte_mode;
  } prc_req_t;

  // Pins driven toward the device.
  typedef struct packed {
    logic [WORD_ADDR_W-1:0] addr;
    logic                   chip_sel_b;
    logic                   out_gate_b;
    logic                   width_sel_b;
    logic                   top_data_pin;
    logic                   top_data_pin_oe;
  } prc_pins_t;

  typedef enum logic [2:0] {
    PRC_POWER_ON,
    PRC_IDLE,
    PRC_RANDOM,
    PRC_PAGE,
    PRC_POWER_OFF,
    PRC_OFF_WAIT
  } prc_state_t;

endpackage : prc_pkg

/* File: prc_timer.sv */
//----------------------------------------------------------------------
// Purpose: Down-counting wait timer for the ROM read controller.
// Assumes: Load wins over counting down.
// Notes:   done_out is high while the count is zero.
//----------------------------------------------------------------------
`timescale 1ns/100ps
module prc_timer #(
  parameter int unsigned W = 20
) (
  input  wire logic         sys_clk_in,  // System clock.
  input  wire logic         rst_b_in,    // Asynchronous reset, active low.
  input  wire logic         load_in,     // Load a new count.
  input  wire logic [W-1:0] count_in,    // Count to load.
  output logic              done_out     // Count has reached zero.
);

  logic [W-1:0] cnt_ff;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_ff <= '0;
    end else if (load_in) begin
      cnt_ff <= count_in;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - W'(1);
    end
  end

  assign done_out = (cnt_ff == '0);

endmodule : prc_timer

/* File: prc_rom_monitor.sv */
// Purpose: Port checker for the page-mode ROM read controller.
// Assumes: Bound to every prc_rom_ctrl instance.
// Notes:   Ages count cycles that the device pins stayed enabled and unchanged, or for page_age_ff kept page and width.
`timescale 1ns/100ps
module prc_rom_monitor #(
  parameter int unsigned POWER_ON_CYCLES  = 20,
  parameter int unsigned POWER_OFF_CYCLES = 20
) (
  input wire logic                       sys_clk_in,     // Clock.
  input wire logic                       rst_b_in,       // Reset, active low.
  input wire logic                       req_valid_in,   // Request.
  input wire prc_pkg::prc_req_t          req_in,         // Request fields.
  input wire logic                       req_ready_out,  // Ready.
  input wire logic                       rd_valid_out,   // Data pulse.
  input wire logic [prc_pkg::DATA_W-1:0] rd_data_out,    // Read data.
  input wire logic                       pwr_off_in,     // Supply off request.
  input wire logic                       pwr_en_out,     // Supply enable.
  input wire prc_pkg::prc_pins_t         pins_out,       // Device pins.
  input wire logic [prc_pkg::DATA_W-1:0] data_pins_in    // Device data.
);
  localparam int unsigned RND_CYC  = prc_pkg::RANDOM_READ_DELAY_NS / prc_pkg::CLK_PERIOD_NS + 1;
  localparam int unsigned PAGE_CYC = prc_pkg::IN_PAGE_DELAY_NS / prc_pkg::CLK_PERIOD_NS + 1;
  int unsigned        on_cnt_ff;
  int unsigned        off_cnt_ff;
  int unsigned        age_ff;
  int unsigned        page_age_ff;
  prc_pkg::prc_pins_t last_ff;
  logic               act;
  assign act = !pins_out.chip_sel_b && !pins_out.out_gate_b;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      on_cnt_ff  <= '0;
      off_cnt_ff <= POWER_OFF_CYCLES;
    end else begin
      on_cnt_ff  <= pwr_en_out ? on_cnt_ff + 32'h1 : '0;
      off_cnt_ff <= pwr_en_out ? '0 : off_cnt_ff + 32'h1;
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      last_ff     <= '0;
      age_ff      <= '0;
      page_age_ff <= '0;
    end else begin
      last_ff     <= pins_out;
      age_ff      <= (act && pins_out == last_ff) ? age_ff + 32'h1 : '0;
      page_age_ff <= (act && {pins_out.addr[24:3], pins_out.width_sel_b} == {last_ff.addr[24:3], last_ff.width_sel_b})
                     ? page_age_ff + 32'h1 : '0;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_take;
    req_valid_in && req_ready_out && !pwr_off_in;
  endsequence
  sequence s_wait_data;
    !req_ready_out ##[2:16] rd_valid_out;
  endsequence
  a_cs_unpowered_high: assert property (!pwr_en_out |-> pins_out.chip_sel_b)
    else $error("chip select low without supply");
  a_power_on_wait: assert property ($fell(pins_out.chip_sel_b) |-> on_cnt_ff >= POWER_ON_CYCLES)
    else $error("read started too soon after power on");
  a_power_off_gap: assert property ($rose(pwr_en_out) |-> off_cnt_ff >= POWER_OFF_CYCLES)
    else $error("supply back on too soon");
  a_byte_pin_drive: assert property (act |-> pins_out.top_data_pin_oe == !pins_out.width_sel_b)
    else $error("top data pin drive does not follow width");
  a_random_hold: assert property (rd_valid_out |-> page_age_ff >= RND_CYC)
    else $error("random address held too briefly");
  a_page_hold: assert property (rd_valid_out |-> age_ff >= PAGE_CYC)
    else $error("in-page address held too briefly");
  a_take_answer: assert property (s_take |=> s_wait_data)
    else $error("no answer after a taken request");
  a_single_pulse: assert property (rd_valid_out |=> !rd_valid_out)
    else $error("data pulse longer than one cycle");
  a_off_request: assert property (pwr_off_in && req_ready_out |-> ##[1:6] !pwr_en_out)
    else $error("supply not removed on request");
endmodule : prc_rom_monitor

bind prc_rom_ctrl prc_rom_monitor #(
  .POWER_ON_CYCLES(POWER_ON_CYCLES), .POWER_OFF_CYCLES(POWER_OFF_CYCLES)
) i_prc_rom_monitor (
  .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid_in), .req_in(req_in),
  .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
  .pwr_off_in(pwr_off_in), .pwr_en_out(pwr_en_out), .pins_out(pins_out), .data_pins_in(data_pins_in)
);

/* File: prc_rom_model.sv */
// Purpose: Behavioural page-mode ROM seen from its pins.
// Assumes: Contents are a fixed function of the word address.
// Notes:   Released or not yet valid lines show the inverse of their last value.
`timescale 1ns/100ps
module prc_rom_model #(
  parameter int unsigned EXTRA_NS = 0
) (
  input  wire logic               pwr_en_in,  // Supply present.
  input  wire prc_pkg::prc_pins_t pins_in,    // Address and controls.
  output logic [15:0]             data_out    // Data as driven by the device.
);
  logic        act_q = 1'b0;
  logic [22:0] key_q = '0;
  int unsigned gen   = 0;
  initial data_out = 16'h0000;
  always @(pins_in or pwr_en_in) begin : resp
    automatic logic        act = pwr_en_in && !pins_in.chip_sel_b && !pins_in.out_gate_b;
    automatic logic [22:0] key = {pins_in.addr[24:3], pins_in.width_sel_b};
    automatic int unsigned dly = ((act_q && key == key_q) ? prc_pkg::IN_PAGE_DELAY_NS
                                 : prc_pkg::RANDOM_READ_DELAY_NS) + EXTRA_NS;
    automatic int unsigned g   = gen + 1;
    automatic logic [15:0] w   = pins_in.addr[15:0] ^ {7'h00, pins_in.addr[24:16]} ^ 16'h3C96;
    automatic logic [15:0] v   = pins_in.width_sel_b ? w
                                 : {~data_out[15:8], pins_in.top_data_pin ? w[15:8] : w[7:0]};
    gen      = g;
    act_q    = act;
    key_q    = key;
    data_out = ~data_out;
    if (act) begin
      fork
        begin
          #(dly);
          if (gen == g) data_out = v;
        end
      join_none
    end
  end
endmodule : prc_rom_model

/* File: prc_rom_ctrl_test.sv */
// Purpose: Self-checking bench for the ROM read controller.
// Assumes: Power waits shortened to 20 cycles.
// Notes:   Expected data is rebuilt from the address and byte_mode alone.
`timescale 1ns/100ps
module prc_rom_ctrl_test;
  localparam int unsigned PW = 20;
  logic               sys_clk   = 1'b0;
  logic               rst_b     = 1'b0;
  logic               req_valid = 1'b0;
  logic               pwr_off   = 1'b0;
  prc_pkg::prc_req_t  req       = '0;
  logic               ready;
  logic               rd_valid;
  logic               pwr_en;
  logic [15:0]        rd_data;
  logic [15:0]        dev;
  logic [15:0]        data_pins;
  prc_pkg::prc_pins_t pins;
  int                 errors    = 0;
  int                 checked   = 0;
  always #5 sys_clk = ~sys_clk;
  assign data_pins = {pins.top_data_pin_oe ? pins.top_data_pin : dev[15], dev[14:0]};
  prc_rom_ctrl #(.POWER_ON_CYCLES(PW), .POWER_OFF_CYCLES(PW)) i_prc_rom_ctrl (
    .sys_clk_in(sys_clk), .rst_b_in(rst_b), .req_valid_in(req_valid), .req_in(req), .req_ready_out(ready),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data), .pwr_off_in(pwr_off), .pwr_en_out(pwr_en),
    .pins_out(pins), .data_pins_in(data_pins));
  prc_rom_model i_prc_rom_model (.pwr_en_in(pwr_en), .pins_in(pins), .data_out(dev));
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t data %h expected %h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_flag(input logic got, input string what);
    checked++;
    if (got !== 1'b1) begin
      errors++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk_flag
  function automatic logic [15:0] exp_rd(input logic [25:0] a, input logic bm);
    logic [24:0] wa;
    logic [15:0] w;
    wa = bm ? a[25:1] : a[24:0];
    w  = wa[15:0] ^ {7'h00, wa[24:16]} ^ 16'h3C96;
    return bm ? {8'h00, a[0] ? w[15:8] : w[7:0]} : w;
  endfunction : exp_rd
  task automatic rd(input logic [25:0] a, input logic bm, input logic fast);
    int n;
    n = 0;
    @(negedge sys_clk);
    req       = '{a, bm};
    req_valid = 1'b1;
    while (ready !== 1'b1 && n < 99) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk_data(rd_data, exp_rd(a, bm));
    chk_flag(fast ? (n >= 3 && n < 8) : (n >= 11 && n < 40), "read latency");
  endtask : rd
  task automatic s_power_up();
    int   n;
    logic cs_hi;
    n     = 0;
    cs_hi = 1'b1;
    while (ready !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      cs_hi &= pins.chip_sel_b;
      n++;
    end
    chk_flag(cs_hi, "select low during power on");
    chk_flag(n >= PW && n < 200, "power-on wait");
  endtask : s_power_up
  task automatic s_word_pages();
    rd(26'h0001235, 1'b0, 1'b0);
    rd(26'h0001236, 1'b0, 1'b1);
    rd(26'h0001230, 1'b0, 1'b1);
    rd(26'h0001238, 1'b0, 1'b0);
    rd(26'h1FFFFFF, 1'b0, 1'b0);
    rd(26'h1FFFFF8, 1'b0, 1'b1);
  endtask : s_word_pages
  task automatic s_byte_pages();
    rd(26'h0002460, 1'b1, 1'b0);
    rd(26'h0002461, 1'b1, 1'b1);
    rd(26'h000246F, 1'b1, 1'b1);
    rd(26'h0002470, 1'b1, 1'b0);
    rd(26'h3FFFFFF, 1'b1, 1'b0);
    rd(26'h0001238, 1'b0, 1'b0);
  endtask : s_byte_pages
  task automatic s_power_cycle();
    int   n;
    logic quiet;
    n     = 0;
    quiet = 1'b1;
    @(negedge sys_clk);
    pwr_off   = 1'b1;
    req_valid = 1'b1;
    req       = '{26'h0001238, 1'b0};
    repeat (8) @(negedge sys_clk);
    chk_flag(!pwr_en && pins.chip_sel_b, "supply still on");
    pwr_off   = 1'b0;
    req_valid = 1'b0;
    while (pwr_en !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      quiet &= !rd_valid;
      n++;
    end
    chk_flag(quiet, "read while off");
    chk_flag(n + 8 >= PW && n < 200, "off gap");
    s_power_up();
    rd(26'h0001238, 1'b0, 1'b0);
  endtask : s_power_cycle
  task automatic wrap_up();
    $display("TB: errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial begin : main
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    s_power_up();
    s_word_pages();
    s_byte_pages();
    s_power_cycle();
    wrap_up();
  end
  // The whole run needs well under 2000 cycles; this cuts a hang short.
  initial begin : watchdog
    #60000;
    errors++;
    wrap_up();
  end
endmodule : prc_rom_ctrl_test
